// ==== rtl/cmpwf_ctrl.sv ====
// apb register file, mode decode, window, sampler and filter of comparator
`timescale 1ns/1ps
`include "cmpwf_params.svh"
module cmpwf_ctrl
   import cmpwf_pkg::*;
#(
   parameter int CNT_W = 3,    // filter_sample_count width
   parameter int PER_W = 8     // filter_sample_period width
)
(
   input  wire logic        pclk,              // bus clock
   input  wire logic        presetn,           // async reset, active low
   input  wire logic        clk_en,            // freezes all state when low
   input  wire logic        psel,              // apb select
   input  wire logic        penable,           // apb access phase
   input  wire logic        pwrite,            // apb direction
   input  wire logic [11:0] paddr,             // apb byte address
   input  wire logic [31:0] pwdata,            // apb write data
   output logic      [31:0] prdata,            // apb read data
   output logic             pready,            // apb ready
   output logic             pslverr,           // apb error, unmapped
   input  wire logic        analog_compare_in, // raw comparator, async
   input  wire logic        window_in,         // window pin, async
   input  wire logic        sample_in,         // external strobe, async
   output logic [2:0]       plus_select,       // noninverting_input mux
   output logic [2:0]       minus_select,      // inverting_input mux
   output logic             comp_power_on,     // comparator powered
   output logic             windowed_out,      // windowed_compare_output
   output logic             final_out,         // final_compare_output
   output logic             irq                // interrupt request
);

   // ------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------
   if (CNT_W < 1 || CNT_W > 3 || PER_W < 1 || PER_W > 8)
   begin : g_bad_param
      $error("cmpwf_ctrl: unsupported parameter width");
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [7:0]       cr0_q;
   logic [7:0]       cr1_q;
   logic [7:0]       fpr_q;
   logic [7:0]       mux_q;
   logic             ier_q;
   logic             ief_q;
   logic             rise_edge_flag_q;
   logic             fall_edge_flag_q;
   logic [1:0]       sync_cmp_q;
   logic [1:0]       sync_win_q;
   logic [2:0]       sync_smp_q;
   logic             windowed_q;
   logic [PER_W-1:0] per_cnt_q;
   logic [7:0]       hist_q;
   logic [3:0]       fill_q;
   logic             filt_q;
   logic             final_q;
   logic             final_prev_q;

   logic [CNT_W-1:0] filter_sample_count;
   logic [PER_W-1:0] filter_sample_period;
   logic             comp_enable;
   logic             output_invert;
   logic             window_enable;
   logic             ext_sample_enable;
   logic             same_inputs;
   logic             raw_compare_result;
   logic             win_level;
   logic             strobe;
   logic             ext_rise;
   logic             filt_reset;
   logic             wr_en;
   logic             rd_en;
   logic [2:0]       reg_idx;
   logic             addr_ok;
   cmpwf_mode_t      mode;

   assign filter_sample_count  = cr0_q[`CMPWF_CR0_CNT_LSB +: CNT_W];
   assign filter_sample_period = fpr_q[PER_W-1:0];
   assign comp_enable          = cr1_q[`CMPWF_CR1_EN];
   assign output_invert        = cr1_q[`CMPWF_CR1_INV];
   assign window_enable        = cr1_q[`CMPWF_CR1_WE];
   assign ext_sample_enable    = cr1_q[`CMPWF_CR1_SE];

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   // zero wait states: pready is a registered constant high
   assign reg_idx = paddr[4:2];
   assign addr_ok = (paddr[`CMPWF_ADDR_W-1:5] == '0) && (paddr[1:0] == 2'b00)
                    && (reg_idx <= `CMPWF_IDX_SCR || reg_idx == `CMPWF_IDX_MUX);
   assign wr_en   = psel && penable && pwrite && addr_ok && clk_en;
   assign rd_en   = psel && !penable && !pwrite;

   // configuration writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cr0_q <= `CMPWF_RST_BYTE;
         cr1_q <= `CMPWF_RST_BYTE;
         fpr_q <= `CMPWF_RST_BYTE;
         mux_q <= `CMPWF_RST_BYTE;
         ier_q <= 1'b0;
         ief_q <= 1'b0;
      end
      else if (wr_en)
      begin
         unique case (reg_idx)
            `CMPWF_IDX_CR0: cr0_q <= pwdata[7:0];
            `CMPWF_IDX_CR1: cr1_q <= pwdata[7:0];
            `CMPWF_IDX_FPR: fpr_q <= pwdata[7:0];
            `CMPWF_IDX_MUX: mux_q <= pwdata[7:0] & `CMPWF_MUX_WMASK;
            `CMPWF_IDX_SCR:
            begin
               ier_q <= pwdata[`CMPWF_SCR_IER];
               ief_q <= pwdata[`CMPWF_SCR_IEF];
            end
            default: ;
         endcase
      end
   end

   // read data, registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (clk_en)
      begin
         pready  <= 1'b1;
         pslverr <= psel && !penable && !addr_ok;
         if (rd_en)
         begin
            prdata <= 32'h0000_0000;
            unique case (reg_idx)
               `CMPWF_IDX_CR0: prdata[7:0] <= cr0_q;
               `CMPWF_IDX_CR1: prdata[7:0] <= cr1_q;
               `CMPWF_IDX_FPR: prdata[7:0] <= fpr_q;
               `CMPWF_IDX_MUX: prdata[7:0] <= mux_q;
               `CMPWF_IDX_SCR:
               begin
                  prdata[`CMPWF_SCR_IER]  <= ier_q;
                  prdata[`CMPWF_SCR_IEF]  <= ief_q;
                  prdata[`CMPWF_SCR_CFR]  <= rise_edge_flag_q;
                  prdata[`CMPWF_SCR_CFF]  <= fall_edge_flag_q;
                  prdata[`CMPWF_SCR_FINAL_COMPARE_OUTPUT] <= final_q;
               end
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // analog mux, shutdown and input synchronisers
   // ------------------------------------------------------------------
   assign same_inputs = (mux_q[5:3] == mux_q[2:0]);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         plus_select   <= 3'h0;
         minus_select  <= 3'h0;
         comp_power_on <= 1'b0;
      end
      else if (clk_en)
      begin
         plus_select   <= mux_q[5:3];
         minus_select  <= mux_q[2:0];
         comp_power_on <= comp_enable && !same_inputs;
      end
   end

   // first stage of each chain feeds only its second stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_cmp_q <= 2'h0;
         sync_win_q <= 2'h0;
         sync_smp_q <= 3'h0;
      end
      else if (clk_en)
      begin
         sync_cmp_q <= {sync_cmp_q[0], analog_compare_in};
         sync_win_q <= {sync_win_q[0], window_in};
         sync_smp_q <= {sync_smp_q[1:0], sample_in};
      end
   end

   // comparator held low when off; polarity applied afterwards
   assign raw_compare_result = sync_cmp_q[1] && comp_power_on;
   assign win_level = raw_compare_result ^ output_invert;
   assign ext_rise  = sync_smp_q[1] && !sync_smp_q[2];

   // ------------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------------
   always_comb
   begin
      if (!comp_enable)
         mode = CMPWF_DISABLED;
      else if (!window_enable)
      begin
         if (ext_sample_enable && filter_sample_count != '0)
            mode = CMPWF_SAMPLED;
         else if (filter_sample_count == '0 || filter_sample_period == '0)
            mode = CMPWF_CONTINUOUS;
         else
            mode = CMPWF_SAMPLED;
      end
      else if (filter_sample_count == '0 || filter_sample_period == '0)
         mode = CMPWF_WINDOWED;
      else
         mode = CMPWF_WIN_SAMPLE;
   end

   assign filt_reset = (filter_sample_count == '0) && !ext_sample_enable;

   // ------------------------------------------------------------------
   // window latch
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         windowed_q <= 1'b0;
      else if (clk_en)
      begin
         if (!window_enable || !comp_enable)
            windowed_q <= win_level;
         else if (sync_win_q[1])
            windowed_q <= win_level;
         // window low: value held
      end
   end

   // ------------------------------------------------------------------
   // sample strobe source
   // ------------------------------------------------------------------
   // internal timebase counts period clocks between strobes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         per_cnt_q <= '0;
      else if (clk_en)
      begin
         if (filt_reset || per_cnt_q + 1'b1 >= filter_sample_period)
            per_cnt_q <= '0;
         else
            per_cnt_q <= per_cnt_q + 1'b1;
      end
   end

   always_comb
   begin
      if (ext_sample_enable)
         strobe = ext_rise;
      else
         strobe = (filter_sample_period != '0) &&
                  (per_cnt_q + 1'b1 >= filter_sample_period);
   end

   // ------------------------------------------------------------------
   // filter: output moves after count agreeing samples
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hist_q <= 8'h00;
         fill_q <= 4'h0;
         filt_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (filt_reset || !comp_enable)
         begin
            hist_q <= 8'h00;
            fill_q <= 4'h0;
            filt_q <= 1'b0;
         end
         else if (strobe)
         begin
            hist_q <= {hist_q[6:0], windowed_q};
            if (fill_q < 4'(filter_sample_count))
               fill_q <= fill_q + 4'h1;
            // agreement of the newest count samples including this one
            if (fill_q + 4'h1 >= 4'(filter_sample_count))
            begin
               if (agree(hist_q, windowed_q, filter_sample_count))
                  filt_q <= windowed_q;
            end
         end
      end
   end

   // true when the last cnt-1 history bits all equal the new sample
   function automatic logic agree(input logic [7:0] h, input logic v,
                                  input logic [CNT_W-1:0] cnt);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 7; i++)
         if (i + 1 < int'(cnt) && h[i] != v)
            ok = 1'b0;
      return ok;
   endfunction

   // ------------------------------------------------------------------
   // final output select and edge flags
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         final_q      <= 1'b0;
         final_prev_q <= 1'b0;
         windowed_out <= 1'b0;
         final_out    <= 1'b0;
      end
      else if (clk_en)
      begin
         unique case (mode)
            CMPWF_DISABLED:   final_q <= output_invert;
            CMPWF_CONTINUOUS: final_q <= win_level;
            CMPWF_WINDOWED:   final_q <= windowed_q;
            CMPWF_SAMPLED,
            CMPWF_WIN_SAMPLE: final_q <= filt_q;
         endcase
         final_prev_q <= final_q;
         windowed_out <= windowed_q;
         final_out    <= final_q;
      end
   end

   // hardware set beats a simultaneous write-one clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rise_edge_flag_q <= 1'b0;
         fall_edge_flag_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (final_q && !final_prev_q)
            rise_edge_flag_q <= 1'b1;
         else if (wr_en && reg_idx == `CMPWF_IDX_SCR && pwdata[`CMPWF_SCR_CFR])
            rise_edge_flag_q <= 1'b0;
         if (!final_q && final_prev_q)
            fall_edge_flag_q <= 1'b1;
         else if (wr_en && reg_idx == `CMPWF_IDX_SCR && pwdata[`CMPWF_SCR_CFF])
            fall_edge_flag_q <= 1'b0;
      end
   end

   // interrupt request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else if (clk_en)
         irq <= (ier_q && rise_edge_flag_q) || (ief_q && fall_edge_flag_q);
   end

endmodule

// ==== rtl/cmpwf_params.svh ====
// register map, field positions and reset values of the comparator control
// Functional notes
// - plus select bits 5..3 pick input 0-7
// - minus select bits 2..0 pick input
// - equal selects force comparator shut down
// - mux bit7 write zero, bit6 reads zero
// - raw result high when plus exceeds minus
// - falling and rising edges set their flags
// - edge enables gate flags onto interrupt
// - final output readable as status bit
// - filter changes after count agreeing samples
// - sample clock internal period or external
// - external enable samples on sample rising edges
// - window enable samples only while window high
// - enable low means disabled mode
// - zero count or period gives continuous mode
// - count one gives sampled unfiltered mode
// - count above one samples and filters
// - windowed capture every clock while window high
// - windowed result resampled at period intervals
// - windowed result resampled and filtered
// - zero count and no sampling resets filter
// - windowed modes hold value when window low
// - filtered output starts zero until filled
// - edge flags clear only on writing one
// - disabled mode holds raw output zero
`ifndef CMPWF_PARAMS_SVH
`define CMPWF_PARAMS_SVH

// byte addresses on the apb (index times four)
`define CMPWF_IDX_CR0     3'h0
`define CMPWF_IDX_CR1     3'h1
`define CMPWF_IDX_FPR     3'h2
`define CMPWF_IDX_SCR     3'h3
`define CMPWF_IDX_MUX     3'h5
`define CMPWF_ADDR_W      12

// control_reg_zero: filter_sample_count in bits 6..4
`define CMPWF_CR0_CNT_LSB 4
// control_reg_one fields
`define CMPWF_CR1_EN      0
`define CMPWF_CR1_INV     4
`define CMPWF_CR1_WE      6
`define CMPWF_CR1_SE      7
// status_control_reg fields
`define CMPWF_SCR_FINAL_COMPARE_OUTPUT    0
`define CMPWF_SCR_CFF     1
`define CMPWF_SCR_CFR     2
`define CMPWF_SCR_IEF     3
`define CMPWF_SCR_IER     4

`define CMPWF_RST_BYTE    8'h00
`define CMPWF_MUX_WMASK   8'h3f

`endif

// ==== rtl/cmpwf_pkg.sv ====
// types shared by the comparator control block
package cmpwf_pkg;
   typedef enum logic [2:0]
   {
      CMPWF_DISABLED   = 3'b000,
      CMPWF_CONTINUOUS = 3'b001,
      CMPWF_SAMPLED    = 3'b011,
      CMPWF_WINDOWED   = 3'b010,
      CMPWF_WIN_SAMPLE = 3'b110
   } cmpwf_mode_t;
endpackage

// ==== tb/cmpwf_analog_model.sv ====
// far-side model: selectable analog inputs and the comparator itself
`timescale 1ns/1ps
module cmpwf_analog_model
#(
   parameter int SETTLE_NS = 30  // comparator settling, 0 answers at once
)
(
   input  wire logic [2:0] plus_select,   // noninverting mux code
   input  wire logic [2:0] minus_select,  // inverting mux code
   input  wire logic       comp_power_on, // comparator powered
   output wire logic       compare_out    // raw comparison level
);
   // input n sits n steps up a ladder, so the higher code wins;
   // a shut-down comparator rests low instead of chattering
   assign #(SETTLE_NS) compare_out =
      comp_power_on && (plus_select > minus_select);
endmodule

// ==== tb/cmpwf_ctrl_chk.sv ====
// port-level assertions for the comparator control block
`timescale 1ns/1ps
`include "cmpwf_params.svh"
module cmpwf_ctrl_chk
(
   input wire logic        pclk,              // bus clock
   input wire logic        presetn,           // reset, active low
   input wire logic        clk_en,            // state freeze when low
   input wire logic        psel,              // apb select
   input wire logic        penable,           // apb access
   input wire logic        pwrite,            // apb direction
   input wire logic [11:0] paddr,             // apb address
   input wire logic [31:0] pwdata,            // apb write data
   input wire logic [31:0] prdata,            // apb read data
   input wire logic        pready,            // apb ready
   input wire logic        pslverr,           // apb error
   input wire logic        analog_compare_in, // raw comparator
   input wire logic        window_in,         // window pin
   input wire logic        sample_in,         // sample strobe
   input wire logic [2:0]  plus_select,       // plus mux code
   input wire logic [2:0]  minus_select,      // minus mux code
   input wire logic        comp_power_on,     // comparator powered
   input wire logic        windowed_out,      // windowed output
   input wire logic        final_out,         // final output
   input wire logic        irq                // interrupt request
);
   localparam logic [11:0] MUX_A = {7'h0, `CMPWF_IDX_MUX, 2'b00};
   logic acc;
   logic mapped;
   logic mux_wr;
   // completed transfers; unused index 4 and 6..7 count as unmapped
   assign acc = psel && penable && pready && clk_en;
   assign mapped = paddr[11:5] == 7'h0 && paddr[1:0] == 2'b00 &&
                   paddr[4:2] != 3'h4 && paddr[4:2] <= 3'h5;
   assign mux_wr = acc && pwrite && paddr == MUX_A;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_power_equal: assert property ((plus_select == minus_select) &&
      $past(plus_select == minus_select) |-> !comp_power_on)
      else $error("comparator powered with equal selects");
   // the register lands at the write edge, the select pins one edge later
   a_mux_load: assert property (mux_wr ##1 clk_en |=> plus_select ==
      $past(pwdata[5:3], 2) && minus_select == $past(pwdata[2:0], 2))
      else $error("mux selects not loaded from write");
   a_mux_hold: assert property (!mux_wr |-> ##2
      $stable(plus_select) && $stable(minus_select))
      else $error("mux selects moved without a write");
   a_mux_reserved: assert property (acc && !pwrite &&
      paddr == MUX_A |-> prdata[7:6] == 2'b00)
      else $error("mux reserved bits read nonzero");
   a_rd_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits nonzero");
   a_bad_addr: assert property (acc && !mapped |->
      pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_ready_up: assert property ($past(presetn) && $past(clk_en) |-> pready)
      else $error("ready low after enabled edge");
   a_freeze_all: assert property (!clk_en |=> $stable(final_out) &&
      $stable(windowed_out) && $stable(irq) && $stable(comp_power_on))
      else $error("state moved while clock enable low");

   c_mux_equal: cover property (mux_wr && pwdata[5:3] == pwdata[2:0]);
   c_irq_rise: cover property ($rose(irq));
   c_bad_addr: cover property (acc && pslverr);
   c_win_rise: cover property ($rose(windowed_out));
endmodule

bind cmpwf_ctrl cmpwf_ctrl_chk u_chk (.pclk, .presetn, .clk_en, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .analog_compare_in, .window_in, .sample_in, .plus_select, .minus_select,
   .comp_power_on, .windowed_out, .final_out, .irq);

// ==== tb/testbench.sv ====
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module testbench;
   typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] x; logic e;}
      cmpwf_row_t;
   logic        pclk, presetn, clk_en, psel, penable, pwrite;
   logic        window_in, sample_in, er;
   logic        pready, pslverr, comp_power_on, windowed_out, final_out, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  plus_select, minus_select;
   wire logic   analog_compare_in;
   int          error_cnt, samples_checked, cyc;
   // address, write byte, expected read byte, expected error
   cmpwf_row_t rows [8] = '{
      '{12'h014, 8'hff, 8'h3f, 1'b0}, '{12'h014, 8'h1a, 8'h1a, 1'b0},
      '{12'h008, 8'ha5, 8'ha5, 1'b0}, '{12'h000, 8'h70, 8'h70, 1'b0},
      '{12'h004, 8'h00, 8'h00, 1'b0}, '{12'h00c, 8'h18, 8'h18, 1'b0},
      '{12'h018, 8'h55, 8'h00, 1'b1}, '{12'h010, 8'h66, 8'h00, 1'b1}};
   logic [11:0] raddr [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h014};

   cmpwf_ctrl dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .analog_compare_in,
      .window_in, .sample_in, .plus_select, .minus_select, .comp_power_on,
      .windowed_out, .final_out, .irq);
   cmpwf_analog_model #(.SETTLE_NS(30)) far_side (.plus_select,
      .minus_select, .comp_power_on, .compare_out(analog_compare_in));

   // ---------------------------------------------------------------
   // clock, hang guard and checking helpers
   // ---------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // the whole run needs under 2000 cycles; a hang is ended at cycle 20000
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         summarize();
      end
   end
   task summarize();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function logic pick(input int s);
      case (s)
         0: pick = final_out;
         1: pick = windowed_out;
         2: pick = irq;
         default: pick = comp_power_on;
      endcase
   endfunction
   // waits are bounded: latency depends on sync, sample and filter depth
   task wait_o(input int s, input logic exp, input string what);
      int n;
      n = 0;
      while (pick(s) !== exp && n < 80)
      begin
         @(posedge pclk);
         n++;
      end
      check(what, pick(s), exp);
   endtask
   task hold(input int s, input int n, input logic exp, input string what);
      logic bad;
      bad = 1'b0;
      repeat (n)
      begin
         @(posedge pclk);
         if (pick(s) !== exp) bad = 1'b1;
      end
      check(what, bad, 1'b0);
   endtask
   // one apb transfer; starts a fresh edge so psel never double-drives
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 50) error_cnt++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task rd_chk(input logic [11:0] a, input logic [7:0] x, input string what);
      apb(1'b0, a, 8'h00);
      check(what, rd, {24'h0, x});
   endtask
   // sampling off and count zero before any filter change
   task cfg(input logic [7:0] c0, fp, c1);
      wr(12'h004, c1 & 8'h7f);
      wr(12'h000, 8'h00);
      wr(12'h008, fp);
      wr(12'h000, c0);
      wr(12'h004, c1);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      logic e1;
      {presetn, psel, penable, pwrite, window_in, sample_in} = 6'h0;
      clk_en = 1'b1;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].w);
         e1 = er;
         rd_chk(rows[i].a, rows[i].x, "reg readback");
         check("write err", e1, rows[i].e);
         check("read err", er, rows[i].e);
      end
      $display("test register table done");
      wr(12'h00c, 8'h06);
      wr(12'h014, 8'h0b);
      cfg(8'h00, 8'h00, 8'h01);
      wait_o(0, 1'b0, "cont low");
      wr(12'h014, 8'h19);
      wait_o(0, 1'b1, "cont high");
      rd_chk(12'h00c, 8'h05, "scr rise");
      check("irq masked", irq, 1'b0);
      wr(12'h00c, 8'h10);
      wait_o(2, 1'b1, "irq rise");
      rd_chk(12'h00c, 8'h15, "flag kept");
      wr(12'h00c, 8'h14);
      wait_o(2, 1'b0, "irq cleared");
      wr(12'h004, 8'h11);
      wait_o(0, 1'b0, "inverted");
      rd_chk(12'h00c, 8'h12, "scr fall");
      check("fall masked", irq, 1'b0);
      wr(12'h00c, 8'h08);
      wait_o(2, 1'b1, "irq fall");
      wr(12'h00c, 8'h06);
      $display("test continuous and flags done");
      wr(12'h014, 8'h12);
      wait_o(3, 1'b0, "equal off");
      wr(12'h014, 8'h19);
      wait_o(3, 1'b1, "differ on");
      wr(12'h004, 8'hd0);
      wait_o(3, 1'b0, "disabled off");
      apb(1'b0, 12'h00c, 8'h00);
      check("dis final_compare_output", rd[0], 1'b1);
      $display("test shutdown done");
      wr(12'h014, 8'h0b);
      cfg(8'h30, 8'h04, 8'h01);
      wr(12'h014, 8'h19);
      hold(0, 5, 1'b0, "filter fill");
      wait_o(0, 1'b1, "filtered high");
      wr(12'h014, 8'h0b);
      wr(12'h014, 8'h19);
      hold(0, 30, 1'b1, "glitch blocked");
      $display("test filter done");
      wr(12'h014, 8'h0b);
      cfg(8'h10, 8'h00, 8'h81);
      wait_o(0, 1'b0, "ext low");
      wr(12'h014, 8'h19);
      hold(0, 20, 1'b0, "no strobe");
      sample_in <= 1'b1;
      repeat (4) @(posedge pclk);
      sample_in <= 1'b0;
      wait_o(0, 1'b1, "strobed");
      $display("test external sample done");
      cfg(8'h00, 8'h00, 8'h41);
      wr(12'h014, 8'h0b);
      hold(1, 20, 1'b1, "window held");
      window_in <= 1'b1;
      wait_o(1, 1'b0, "window open");
      window_in <= 1'b0;
      repeat (4) @(posedge pclk);
      wr(12'h014, 8'h19);
      hold(1, 20, 1'b0, "window shut");
      window_in <= 1'b1;
      wait_o(1, 1'b1, "window follow");
      wr(12'h014, 8'h0b);
      cfg(8'h10, 8'h03, 8'h41);
      wr(12'h014, 8'h19);
      wait_o(0, 1'b1, "resampled");
      cfg(8'h30, 8'h02, 8'h41);
      hold(0, 3, 1'b0, "win filter fill");
      wait_o(0, 1'b1, "win filtered");
      clk_en <= 1'b0;
      window_in <= 1'b0;
      repeat (5) @(posedge pclk);
      clk_en <= 1'b1;
      $display("test window done");
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      check("reset outs", {final_out, irq, comp_power_on}, 3'b000);
      presetn <= 1'b1;
      foreach (raddr[i])
         rd_chk(raddr[i], 8'h00, "reset value");
      $display("test reset done");
      summarize();
   end
endmodule
